/* hdl/rcf_defines.svh */
// register offsets, field positions, reset values and field lengths
// assumes byte addressing on a 32-bit avalon-mm register bus
`ifndef RCF_DEFINES_SVH
`define RCF_DEFINES_SVH

`define RCF_OFS_CTRL    8'h00
`define RCF_OFS_STATUS  8'h04
`define RCF_OFS_LABEL   8'h08
`define RCF_OFS_MGMT    8'h0c
`define RCF_OFS_IDS     8'h10
`define RCF_OFS_QUAL    8'h14
`define RCF_OFS_MOB     8'h18
`define RCF_OFS_REQCFG  8'h1c
`define RCF_OFS_REQ0    8'h20

`define RCF_CTRL_START  0
`define RCF_CTRL_ROUTE  1
`define RCF_CTRL_REQ    2
`define RCF_CTRL_MGMT   3
`define RCF_CTRL_GROUP  4
`define RCF_CTRL_SESS   5
`define RCF_CTRL_QUAL   6
`define RCF_CTRL_MOB    7
`define RCF_CTRL_NODEM  8
`define RCF_CTRL_ECHO   9

`define RCF_CTRL_RST    10'h0c2

`define RCF_MC_NONE     16'h0000
`define RCF_MC_FINE     16'h0001
`define RCF_MC_LOGOFF   16'h0002
`define RCF_MC_RSV_LAST 16'h7fff
`define RCF_MC_ECHO     1'h1

`define RCF_CAT_VOL     2'h0
`define RCF_CAT_RATE    2'h1
`define RCF_CAT_AVOL    2'h2
`define RCF_CAT_RSV     2'h3

`define RCF_LEN_LABEL   12'h010
`define RCF_LEN_MGMT    12'h010
`define RCF_LEN_GROUP   12'h008
`define RCF_LEN_SESS    12'h010
`define RCF_LEN_QUAL    12'h010
`define RCF_LEN_MOB     12'h020
`define RCF_LEN_REQ_S   12'h010
`define RCF_LEN_REQ_L   12'h014
`define RCF_SH_WIDTH    12'h020

`endif

/* hdl/rcf_pkg.sv */
// types shared by the burst signalling field builder
// assumes nothing beyond a systemverilog compiler
package rcf_pkg;

  typedef enum logic [3:0] {
    RCF_IDLE   = 4'h0,
    RCF_LABEL  = 4'h1,
    RCF_REQ    = 4'h2,
    RCF_REQPAD = 4'h3,
    RCF_MGMT   = 4'h4,
    RCF_GROUP  = 4'h5,
    RCF_SESS   = 4'h6,
    RCF_QUAL   = 4'h7,
    RCF_MOB    = 4'h8,
    RCF_PAD    = 4'h9
  } rcf_phase_type;

endpackage

/* hdl/rcf_field_builder.sv */
// serialiser for the per-burst signalling field of a return-link terminal
// assumes one clock, avalon-mm register access, a bit sink with ready
//
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`include "rcf_defines.svh"

// What this block does
// [RQ1] routing label sent only when flag is 0
// [RQ2] requests sent when flag 1, count plus one
// [RQ3] management code sent only when flag is 1
// [RQ4] group/session on flag 1, quality/mobility on 0
// [RQ5] routing label is a 16-bit value
// [RQ6] scale bit: multiplier 1 clear, 16 set
// [RQ7] format bit 0: 4-bit selector, 1: 8-bit
// [RQ8] category 00/01/10, code 11 never sent
// [RQ9] volume units payload size, rate 2 kbit/s
// [RQ10] selector 0000 means any channel
// [RQ11] request amount is 8-bit unsigned
// [RQ12] unused request area filled with zero bytes
// [RQ13] no demand: one volume request of 0
// [RQ14] management codes 0, 1, 2, echo 8000-ffff
// [RQ15] fine-sync code sent once synchronised
// [RQ16] echo reply sent in the echo range
// [RQ17] group number is 8 bits
// [RQ18] session number is 16 bits
// [RQ19] quality: 8-bit ratio then 8-bit modcod request
// [RQ20] 32-bit mobility message supported
// [RQ21] zero bytes pad to configured field length
// [RQ22] sub-fields in fixed order
// [RQ23] msb first, no gaps besides padding
module rcf_field_builder
  import rcf_pkg::*;
#(
  parameter int NREQ = 8
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             field_bit,
  output logic             field_valid,
  input  wire logic        field_ready,
  output logic             field_last
);

  localparam int IW = $clog2(NREQ);

  typedef struct packed {
    rcf_phase_type         phase;
    logic                  go;
    logic [11:0]           cnt;
    logic [31:0]           sh;
    logic [IW-1:0]         idx;
    logic [11:0]           req_bits;
    logic [11:0]           total;
    logic                  ack;
    logic [31:0]           rdata;
    logic [9:0]            ctrl;
    logic [15:0]           label;
    logic [15:0]           mgmt;
    logic [14:0]           echo;
    logic [7:0]            group;
    logic [15:0]           sess;
    logic [15:0]           qual;
    logic [31:0]           mob;
    logic [IW-1:0]         count;
    logic [7:0]            area;
    logic [7:0]            flen;
    logic [NREQ-1:0][19:0] ent;
    logic                  err_cat;
    logic                  err_mc;
    logic [7:0]            frames;
  } rcf_state_type;

  rcf_state_type s_q;
  rcf_state_type s_d;

  function automatic logic [31:0] be_merge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // no-demand overrides the table with one all-zero volume request
  function automatic logic [19:0] ent_raw(input rcf_state_type s, input logic [IW-1:0] i);
    logic [19:0] e;
    e = s.ctrl[`RCF_CTRL_NODEM] ? 20'h00000 : s.ent[i]; // see [RQ13] see [RQ10]
    // a reserved category is sent as volume so the far end never sees 11
    if (e[17:16] == `RCF_CAT_RSV) begin
      e[17:16] = `RCF_CAT_VOL; // see [RQ8]
    end
    return e;
  endfunction

  function automatic logic [11:0] ent_len(input rcf_state_type s, input logic [IW-1:0] i);
    logic [19:0] e;
    e = ent_raw(s, i);
    return e[18] ? `RCF_LEN_REQ_L : `RCF_LEN_REQ_S; // see [RQ7]
  endfunction

  // scale, format, category, selector, amount; selector width by format
  function automatic logic [31:0] ent_word(input rcf_state_type s, input logic [IW-1:0] i);
    logic [19:0] e;
    e = ent_raw(s, i);
    if (e[18]) begin
      return {12'h000, e[19], e[18], e[17:16], e[15:8], e[7:0]}; // see [RQ6] see [RQ11]
    end
    return {16'h0000, e[19], e[18], e[17:16], e[11:8], e[7:0]}; // see [RQ7] see [RQ9]
  endfunction

  // echo pattern lands in the top half; reserved codes degrade to no message
  function automatic logic [15:0] mc_code(input rcf_state_type s);
    if (s.ctrl[`RCF_CTRL_ECHO]) begin
      return {`RCF_MC_ECHO, s.echo}; // see [RQ16]
    end
    if (s.mgmt > `RCF_MC_LOGOFF && s.mgmt <= `RCF_MC_RSV_LAST) begin
      return `RCF_MC_NONE; // see [RQ14]
    end
    return s.mgmt; // see [RQ15]
  endfunction

  function automatic logic [11:0] seg_len(input rcf_phase_type p, input rcf_state_type s,
                                          input logic [11:0] e, input logic [11:0] ru);
    logic [11:0] lim;
    lim = 12'h000;
    unique case (p)
      RCF_LABEL:  lim = !s.ctrl[`RCF_CTRL_ROUTE] ? `RCF_LEN_LABEL : 12'h000; // see [RQ1]
      RCF_REQ:    lim = s.ctrl[`RCF_CTRL_REQ] ? ent_len(s, '0) : 12'h000; // see [RQ2]
      RCF_REQPAD: begin
        lim = {1'b0, s.area, 3'h0};
        lim = (s.ctrl[`RCF_CTRL_REQ] && lim > ru) ? lim - ru : 12'h000; // see [RQ12]
      end
      RCF_MGMT:   lim = s.ctrl[`RCF_CTRL_MGMT] ? `RCF_LEN_MGMT : 12'h000; // see [RQ3]
      RCF_GROUP:  lim = s.ctrl[`RCF_CTRL_GROUP] ? `RCF_LEN_GROUP : 12'h000; // see [RQ4]
      RCF_SESS:   lim = s.ctrl[`RCF_CTRL_SESS] ? `RCF_LEN_SESS : 12'h000; // see [RQ4]
      RCF_QUAL:   lim = !s.ctrl[`RCF_CTRL_QUAL] ? `RCF_LEN_QUAL : 12'h000; // see [RQ4]
      RCF_MOB:    lim = !s.ctrl[`RCF_CTRL_MOB] ? `RCF_LEN_MOB : 12'h000; // see [RQ4]
      RCF_PAD: begin
        lim = {1'b0, s.flen, 3'h0};
        lim = (lim > e) ? lim - e : 12'h000; // see [RQ21]
      end
      default:    lim = 12'h000;
    endcase
    return lim;
  endfunction

  function automatic logic [31:0] seg_word(input rcf_phase_type p, input rcf_state_type s);
    logic [31:0] w;
    w = 32'h0;
    unique case (p)
      RCF_LABEL: w = {16'h0, s.label}; // see [RQ5]
      RCF_REQ:   w = ent_word(s, '0);
      RCF_MGMT:  w = {16'h0, mc_code(s)};
      RCF_GROUP: w = {24'h0, s.group}; // see [RQ17]
      RCF_SESS:  w = {16'h0, s.sess}; // see [RQ18]
      RCF_QUAL:  w = {16'h0, s.qual}; // see [RQ19]
      RCF_MOB:   w = s.mob; // see [RQ20]
      default:   w = 32'h0;
    endcase
    return w;
  endfunction

  logic          busy;
  logic          fire;
  logic          seg_end;
  logic          more_req;
  logic          do_search;
  logic          found;
  rcf_phase_type np;
  logic [11:0]   nl;
  logic [31:0]   wr;
  logic [IW-1:0] last_idx;
  logic [IW-1:0] ai;
  logic          req_load;

  assign busy            = s_q.go || (s_q.phase != RCF_IDLE);
  assign fire            = (s_q.phase != RCF_IDLE) && field_ready;
  assign seg_end         = fire && (s_q.cnt == 12'h001);
  assign last_idx        = s_q.ctrl[`RCF_CTRL_NODEM] ? '0 : s_q.count;
  assign more_req        = (s_q.phase == RCF_REQ) && (s_q.idx < last_idx);
  assign do_search       = s_q.go || (seg_end && !more_req);
  assign avs_waitrequest = (avs_read || avs_write) && !s_q.ack;
  assign avs_readdata    = s_q.rdata;
  assign field_valid     = s_q.phase != RCF_IDLE;
  assign field_bit       = s_q.sh[31]; // see [RQ23]
  assign field_last      = seg_end && !more_req && !found;
  assign ai              = IW'((avs_address - `RCF_OFS_REQ0) >> 2);

  // first present segment after the current one; order is the enum order
  always_comb begin
    logic [11:0]   e;
    logic [11:0]   ru;
    logic [11:0]   l;
    rcf_phase_type sp;
    e     = s_q.go ? 12'h000 : 12'(s_q.total + 12'h001);
    ru    = (s_q.phase == RCF_REQ) ? 12'(s_q.req_bits + 12'h001) : s_q.req_bits;
    sp    = s_q.go ? RCF_LABEL : rcf_phase_type'(s_q.phase + 4'h1);
    found = 1'b0;
    np    = RCF_IDLE;
    nl    = 12'h000;
    l     = 12'h000;
    for (int p = 1; p <= 9; p++) begin
      if (!found && p >= int'(sp)) begin
        l = seg_len(rcf_phase_type'(p[3:0]), s_q, e, ru);
        if (l != 12'h000) begin
          found = 1'b1; // see [RQ22]
          np    = rcf_phase_type'(p[3:0]);
          nl    = l;
        end
      end
    end
  end

  always_comb begin
    s_d      = s_q;
    wr       = be_merge(32'h0, avs_writedata, avs_byteenable);
    req_load = 1'b0;
    s_d.ack  = (avs_read || avs_write) && !s_q.ack;

    // read data is captured in the wait cycle and presented on the ack cycle
    if ((avs_read || avs_write) && !s_q.ack) begin
      s_d.rdata = 32'h0;
      if (avs_read && avs_address[1:0] == 2'h0) begin
        unique case (avs_address)
          `RCF_OFS_CTRL:   s_d.rdata = {22'h0, s_q.ctrl};
          `RCF_OFS_STATUS: s_d.rdata = {20'h0, s_q.frames, 1'b0, s_q.err_mc,
                                        s_q.err_cat, busy};
          `RCF_OFS_LABEL:  s_d.rdata = {16'h0, s_q.label};
          `RCF_OFS_MGMT:   s_d.rdata = {1'b0, s_q.echo, s_q.mgmt};
          `RCF_OFS_IDS:    s_d.rdata = {8'h0, s_q.sess, s_q.group};
          `RCF_OFS_QUAL:   s_d.rdata = {16'h0, s_q.qual};
          `RCF_OFS_MOB:    s_d.rdata = s_q.mob;
          `RCF_OFS_REQCFG: s_d.rdata = {8'h0, s_q.flen, s_q.area, 8'(s_q.count)};
          default: begin
            if (avs_address >= `RCF_OFS_REQ0
                && avs_address < 8'(`RCF_OFS_REQ0 + 8'(4 * NREQ))) begin
              s_d.rdata = {12'h0, s_q.ent[ai]};
            end
          end
        endcase
      end
    end

    // configuration is frozen while a field is on the wire
    if (s_q.ack && avs_write && !busy && avs_address[1:0] == 2'h0) begin
      unique case (avs_address)
        `RCF_OFS_CTRL: begin
          s_d.ctrl = 10'(be_merge({22'h0, s_q.ctrl}, avs_writedata, avs_byteenable));
          s_d.ctrl[`RCF_CTRL_START] = 1'b0;
          if (wr[`RCF_CTRL_START]) begin
            s_d.go       = 1'b1;
            s_d.total    = 12'h000;
            s_d.req_bits = 12'h000;
            s_d.err_cat  = 1'b0;
            s_d.err_mc   = 1'b0;
          end
        end
        `RCF_OFS_LABEL: s_d.label = 16'(be_merge({16'h0, s_q.label}, avs_writedata,
                                                 avs_byteenable));
        `RCF_OFS_MGMT: begin
          wr         = be_merge({1'b0, s_q.echo, s_q.mgmt}, avs_writedata, avs_byteenable);
          s_d.mgmt   = wr[15:0];
          s_d.echo   = wr[30:16];
        end
        `RCF_OFS_IDS: begin
          wr        = be_merge({8'h0, s_q.sess, s_q.group}, avs_writedata, avs_byteenable);
          s_d.group = wr[7:0];
          s_d.sess  = wr[23:8];
        end
        `RCF_OFS_QUAL: s_d.qual = 16'(be_merge({16'h0, s_q.qual}, avs_writedata,
                                               avs_byteenable));
        `RCF_OFS_MOB: s_d.mob = be_merge(s_q.mob, avs_writedata, avs_byteenable);
        `RCF_OFS_REQCFG: begin
          wr        = be_merge({8'h0, s_q.flen, s_q.area, 8'(s_q.count)}, avs_writedata,
                               avs_byteenable);
          s_d.count = wr[IW-1:0];
          s_d.area  = wr[15:8];
          s_d.flen  = wr[23:16];
        end
        default: begin
          if (avs_address >= `RCF_OFS_REQ0
              && avs_address < 8'(`RCF_OFS_REQ0 + 8'(4 * NREQ))) begin
            s_d.ent[ai] = 20'(be_merge({12'h0, s_q.ent[ai]}, avs_writedata,
                                       avs_byteenable));
          end
        end
      endcase
    end

    if (fire) begin
      s_d.total = 12'(s_q.total + 12'h001);
      s_d.sh    = {s_q.sh[30:0], 1'b0}; // see [RQ23]
      s_d.cnt   = 12'(s_q.cnt - 12'h001);
      if (s_q.phase == RCF_REQ) begin
        s_d.req_bits = 12'(s_q.req_bits + 12'h001);
      end
    end

    if (seg_end && more_req) begin
      s_d.idx  = IW'(s_q.idx + 1'b1); // see [RQ2]
      s_d.cnt  = ent_len(s_q, IW'(s_q.idx + 1'b1));
      s_d.sh   = ent_word(s_q, IW'(s_q.idx + 1'b1)) << (`RCF_SH_WIDTH - s_d.cnt);
      req_load = 1'b1;
      if (s_q.ent[IW'(s_q.idx + 1'b1)][17:16] == `RCF_CAT_RSV
          && !s_q.ctrl[`RCF_CTRL_NODEM]) begin
        s_d.err_cat = 1'b1;
      end
    end else if (do_search) begin
      s_d.go = 1'b0;
      if (found) begin
        s_d.phase = np;
        s_d.cnt   = nl;
        s_d.idx   = '0;
        s_d.sh    = seg_word(np, s_q) << (`RCF_SH_WIDTH - nl);
        req_load  = (np == RCF_REQ);
        if (np == RCF_REQ && s_q.ent[0][17:16] == `RCF_CAT_RSV
            && !s_q.ctrl[`RCF_CTRL_NODEM]) begin
          s_d.err_cat = 1'b1;
        end
        if (np == RCF_MGMT && !s_q.ctrl[`RCF_CTRL_ECHO]
            && s_q.mgmt > `RCF_MC_LOGOFF && s_q.mgmt <= `RCF_MC_RSV_LAST) begin
          s_d.err_mc = 1'b1;
        end
      end else begin
        s_d.phase  = RCF_IDLE;
        s_d.sh     = 32'h0;
        s_d.frames = 8'(s_q.frames + 8'h01);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_q      <= '0;
      s_q.ctrl <= `RCF_CTRL_RST;
    end else begin
      s_q <= s_d;
    end
  end

  sequence seq_stalled;
    (s_q.phase != RCF_IDLE) && !field_ready;
  endsequence
  sequence seq_seg_change;
    fire && (s_q.cnt == 12'h001) && !more_req;
  endsequence

  AST_LABEL_FLAG: assert property (@(posedge sys_clk) disable iff (rst) // see [RQ1]
    s_q.phase == RCF_LABEL |-> !s_q.ctrl[`RCF_CTRL_ROUTE])
    else $error("routing label sent while its flag is set");
  AST_REQ_COUNT: assert property (@(posedge sys_clk) disable iff (rst) // see [RQ2]
    s_q.phase == RCF_REQ |-> s_q.ctrl[`RCF_CTRL_REQ] && s_q.idx <= last_idx)
    else $error("capacity request outside flag or count");
  AST_MGMT_FLAG: assert property (@(posedge sys_clk) disable iff (rst) // see [RQ3]
    s_q.phase == RCF_MGMT |-> s_q.ctrl[`RCF_CTRL_MGMT])
    else $error("management code sent while its flag is clear");
  AST_OPT_FLAGS: assert property (@(posedge sys_clk) disable iff (rst) // see [RQ4]
    (s_q.phase == RCF_GROUP |-> s_q.ctrl[`RCF_CTRL_GROUP])
    and (s_q.phase == RCF_SESS |-> s_q.ctrl[`RCF_CTRL_SESS])
    and (s_q.phase == RCF_QUAL |-> !s_q.ctrl[`RCF_CTRL_QUAL])
    and (s_q.phase == RCF_MOB |-> !s_q.ctrl[`RCF_CTRL_MOB]))
    else $error("optional sub-field sent against its flag");
  AST_NO_RSV_CAT: assert property (@(posedge sys_clk) disable iff (rst) // see [RQ8]
    req_load |=> (s_q.cnt == `RCF_LEN_REQ_L ? s_q.sh[29:28] : s_q.sh[29:28])
                 != `RCF_CAT_RSV)
    else $error("reserved request category on the wire");
  AST_MC_RANGE: assert property (@(posedge sys_clk) disable iff (rst) // see [RQ14]
    $rose(s_q.phase == RCF_MGMT) |->
      s_q.sh[31:16] <= `RCF_MC_LOGOFF || s_q.sh[31])
    else $error("reserved management code on the wire");
  AST_PAD_ZERO: assert property (@(posedge sys_clk) disable iff (rst) // see [RQ12]
    (s_q.phase == RCF_REQPAD || s_q.phase == RCF_PAD) |-> !field_bit)
    else $error("padding bit is not zero");
  AST_ORDER: assert property (@(posedge sys_clk) disable iff (rst) // see [RQ22]
    seq_seg_change |=> s_q.phase == RCF_IDLE || s_q.phase > $past(s_q.phase))
    else $error("sub-fields out of order");
  AST_STALL_HOLD: assert property (@(posedge sys_clk) disable iff (rst) // see [RQ23]
    seq_stalled |=> $stable(field_bit) && $stable(s_q.cnt) && $stable(s_q.phase))
    else $error("bit changed while the sink stalled");
  AST_FIELD_LEN: assert property (@(posedge sys_clk) disable iff (rst) // see [RQ21]
    field_last |-> 12'(s_q.total + 12'h001) >= {1'b0, s_q.flen, 3'h0})
    else $error("field ended short of the configured length");
  AST_BUS_ANSWER: assert property (@(posedge sys_clk) disable iff (rst)
    (avs_read || avs_write) && avs_waitrequest ##1 (avs_read || avs_write)
      |-> !avs_waitrequest)
    else $error("bus access not answered after one wait cycle");

endmodule

/* verif/rcf_sink.sv */
// partner model: serial bit sink standing for the network control centre
// assumes the builder's sys_clk domain and its bit, valid, ready, last port
`timescale 1ns/1ps
module rcf_sink (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic field_bit,
  input  wire logic field_valid,
  input  wire logic field_last,
  input  wire logic slow,
  output logic      field_ready
);
  logic got[$];
  int   last_at;
  int   n_last;

  // random stalls per cycle, so a held bit must survive ready low
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      field_ready <= 1'b0;
    end else begin
      field_ready <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
    end
  end

  // bits kept raw; the bench compares them one by one with the field
  // that its own model builds, without decoding any of the sub-fields
  always @(posedge sys_clk) begin
    if (!rst && field_valid && field_ready) begin
      got.push_back(field_bit);
      if (field_last) begin
        last_at = got.size();
        n_last++;
      end
    end
  end
endmodule

/* verif/return_ctrl_field_builder_tb_top.sv */
// self-checking bench: register set-up over avalon-mm, frames into the sink
// assumes rcf_field_builder with nreq 8 and the sink model beside it
`timescale 1ns/1ps
`include "rcf_defines.svh"
module return_ctrl_field_builder_tb_top;
  logic        sys_clk;
  logic        rst;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        field_bit;
  logic        field_valid;
  logic        field_ready;
  logic        field_last;
  logic        slow;
  int          n_fail;
  int          n_tests;
  int          ctrl, label, mgmt, ids, qual, mob, reqcfg, errs, frames;
  int          req[8];
  int          mc[6] = '{0, 1, 2, 5, 'h8123, 0};
  bit          exp[$];
  logic [31:0] q;

  rcf_field_builder #(.NREQ(8)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .field_bit(field_bit),
    .field_valid(field_valid), .field_ready(field_ready), .field_last(field_last));
  rcf_sink i_sink (
    .sys_clk(sys_clk), .rst(rst), .field_bit(field_bit), .field_valid(field_valid),
    .field_last(field_last), .slow(slow), .field_ready(field_ready));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("counts: %0d compared, %0d wrong", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %0s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // request raised after an edge, held until waitrequest seen low at an edge
  task automatic bus_op(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] rd);
    int n;
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) begin
      n_fail++;
      close_out();
    end
    check("wait cycles", 1, n - 1);
  endtask

  function automatic void push(int v, int n);
    for (int i = n - 1; i >= 0; i--) exp.push_back(v[i]);
  endfunction

  function automatic void pushz(int n);
    for (int i = 0; i < n; i++) exp.push_back(1'b0);
  endfunction

  function automatic void build();
    int nb, e, c, m;
    exp.delete();
    errs = 0;
    if (!ctrl[1]) push(label, 16);
    if (ctrl[2]) begin
      nb = 0;
      if (ctrl[8]) begin
        push(0, 16);
        nb = 16;
      end else begin
        for (int i = 0; i <= reqcfg[2:0]; i++) begin
          e = req[i];
          c = e[17:16];
          if (c == 3) begin
            c = 0;
            errs |= 2;
          end
          push({e[19], e[18], c[1:0]}, 4);
          push(e[18] ? e[15:8] : e[11:8], e[18] ? 8 : 4);
          push(e[7:0], 8);
          nb += e[18] ? 20 : 16;
        end
      end
      pushz(reqcfg[15:8] * 8 - nb);
    end
    if (ctrl[3]) begin
      m = ctrl[9] ? {1'b1, mgmt[30:16]} : mgmt[15:0];
      if (!ctrl[9] && m > 2 && m < 'h8000) begin
        m = 0;
        errs |= 4;
      end
      push(m, 16);
    end
    if (ctrl[4]) push(ids[7:0], 8);
    if (ctrl[5]) push(ids[23:8], 16);
    if (!ctrl[6]) push(qual[15:0], 16);
    if (!ctrl[7]) push(mob, 32);
    pushz(reqcfg[23:16] * 8 - exp.size());
  endfunction

  task automatic cfg();
    bus_op(1, `RCF_OFS_LABEL, label, 4'hf, q);
    bus_op(1, `RCF_OFS_MGMT, mgmt, 4'hf, q);
    bus_op(1, `RCF_OFS_IDS, ids, 4'hf, q);
    bus_op(1, `RCF_OFS_QUAL, qual, 4'hf, q);
    bus_op(1, `RCF_OFS_MOB, mob, 4'hf, q);
    bus_op(1, `RCF_OFS_REQCFG, reqcfg, 4'hf, q);
    for (int i = 0; i < 8; i++) bus_op(1, `RCF_OFS_REQ0 + 8'(4 * i), req[i], 4'hf, q);
  endtask

  // start, optionally poke label while busy, then compare the whole field
  task automatic frame(input string nm, input logic s, input logic poke);
    int n, l0;
    i_sink.got.delete();
    l0 = i_sink.n_last;
    slow <= s;
    build();
    bus_op(1, `RCF_OFS_CTRL, ctrl | 1, 4'hf, q);
    frames++;
    if (poke) bus_op(1, `RCF_OFS_LABEL, 'h5a5a, 4'hf, q);
    n = 0;
    do begin
      bus_op(0, `RCF_OFS_STATUS, 0, 4'h0, q);
      n++;
    end while (q[0] !== 1'b0 && n < 2000);
    if (n >= 2000) begin
      n_fail++;
      close_out();
    end
    check("status errors", errs, {29'h0, q[2:1], 1'b0});
    check("frame count", frames & 'hff, q[11:4]);
    check("bit count", exp.size(), i_sink.got.size());
    for (int i = 0; i < exp.size() && i < i_sink.got.size(); i++)
      check("field bit", exp[i], i_sink.got[i]);
    check("last marks", l0 + 1, i_sink.n_last);
    check("last position", exp.size(), i_sink.last_at);
    bus_op(0, `RCF_OFS_CTRL, 0, 4'h0, q);
    check("ctrl readback", ctrl, q);
    bus_op(0, `RCF_OFS_LABEL, 0, 4'h0, q);
    check("label kept", label, q);
    bus_op(0, `RCF_OFS_REQ0 + 8'h1c, 0, 4'h0, q);
    check("request entry kept", req[7] & 'hfffff, q);
    $display("test %0s done", nm);
  endtask

  initial begin
    rst = 1'b1;
    slow = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    n_fail = 0;
    n_tests = 0;
    frames = 0;
    void'($urandom(13));
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    bus_op(0, `RCF_OFS_CTRL, 0, 4'h0, q);
    check("ctrl reset", `RCF_CTRL_RST, q);
    bus_op(0, `RCF_OFS_STATUS, 0, 4'h0, q);
    check("status reset", 0, q);
    bus_op(0, 8'h40, 0, 4'h0, q);
    check("unmapped read", 0, q);
    bus_op(0, 8'h09, 0, 4'h0, q);
    check("misaligned read", 0, q);
    bus_op(1, `RCF_OFS_LABEL, 'hffff, 4'hf, q);
    bus_op(1, `RCF_OFS_LABEL, 'h0012, 4'h1, q);
    bus_op(0, `RCF_OFS_LABEL, 0, 4'h0, q);
    check("byte lane merge", 'hff12, q);
    $display("test registers done");
    // label only, exact length: last flag on bit 16, busy write dropped
    ctrl = 'h0c0;
    label = 'hff12;
    reqcfg = 'h020000;
    bus_op(1, `RCF_OFS_REQCFG, reqcfg, 4'hf, q);
    frame("label only", 1'b1, 1'b1);
    for (int k = 0; k < 8; k++) begin
      ctrl = ($urandom & 'h0f2) | 'h00c | (k == 6 ? 'h100 : 0) | (k == 5 ? 'h200 : 0);
      label = $urandom & 'hffff;
      mgmt = ($urandom & 'h7fff0000) | mc[k % 6];
      ids = $urandom & 'hffffff;
      qual = $urandom & 'hffff;
      mob = $urandom;
      reqcfg = (35 + $urandom % 3) << 16 | (20 + $urandom % 3) << 8 | $urandom % 8;
      for (int i = 0; i < 8; i++) req[i] = $urandom & 'hfffff;
      req[0] = (req[0] & 'hcffff) | (k % 4) << 16;
      cfg();
      frame("random frame", k[0], 1'b0);
    end
    close_out();
  end
endmodule
